// ### hw/ifcap_top.sv
// Notes on behaviour
// - pins zero to six flag falling edges
// - pin seven edge chosen by control bit
// - software clears flags, never sets them
// - masked view reads zero when masked off
// - raw view shows events regardless of mask
// - either view clears same pending bit
// - internal flags: timer, counters, energy, uart, cid, serial
// - page bits steer raw window address
// - core vectors to eight
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "ifcap_cfg.svh"
module ifcap_top
   import ifcap_pkg::*;
(
   // apb
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // port seven pins
   input  wire logic [7:0]  port_seven_pins,
   // internal event pulses
   input  wire logic        timer_evt,
   input  wire logic        counter_one_evt,
   input  wire logic        counter_two_evt,
   input  wire logic        line_energy_evt,
   input  wire logic        uart_evt,
   input  wire logic        callerid_decode_evt,
   input  wire logic        serial_full_or_tone_evt,
   // interrupts
   output logic             irq_pending,
   output logic             irq,
   output logic [15:0]      irq_vector
);
   ////////////////////////////////////////////////////////////////////
   logic [7:0] sync1_reg;
   logic [7:0] sync2_reg;
   logic [7:0] ext_raw_reg;
   logic [7:0] ext_raw_next;
   logic [7:0] int_raw_reg;
   logic [7:0] int_raw_next;
   logic [7:0] ext_mask_reg;
   logic [7:0] int_mask_reg;
   logic [7:0] counter_control_reg;
   logic [1:0] reg_page_select;
   logic [1:0] irq_stat_reg;
   logic [1:0] irq_stat_next;
   logic [1:0] irq_mask_reg;
   logic [7:0] int_evt;
   logic [7:0] ext_masked_flags;
   logic [7:0] internal_masked_flags;
   ifcap_edge_if eif ();

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1_reg <= 8'hff;
         sync2_reg <= 8'hff;
      end
      else
      begin
         sync1_reg <= port_seven_pins;
         sync2_reg <= sync1_reg;
      end
   end
   assign eif.pin_sync = sync2_reg;
   assign eif.rise_sel = counter_control_reg[`IFCAP_CTRL_P7_RISE];

   ifcap_edge u_edge
   (
      .pclk    (pclk),
      .presetn (presetn),
      .e       (eif.det)
   );

   ////////////////////////////////////////////////////////////////////
   // apb decode
   wire        wr_acc  = psel & penable & pwrite;
   wire        rd_acc  = psel & penable & ~pwrite;
   wire        lane0   = pstrb[0];
   wire        hit_er  = paddr == `IFCAP_OFF_EXT_RAW;
   wire        hit_ir  = paddr == `IFCAP_OFF_INT_RAW;
   wire        hit_em  = paddr == `IFCAP_OFF_EXT_MASKED;
   wire        hit_im  = paddr == `IFCAP_OFF_INT_MASKED;
   wire        hit_ek  = paddr == `IFCAP_OFF_EXT_MASK;
   wire        hit_ik  = paddr == `IFCAP_OFF_INT_MASK;
   wire        hit_ct  = paddr == `IFCAP_OFF_CTRL;
   wire        hit_st  = paddr == `IFCAP_OFF_STATUS;
   wire        hit_is  = paddr == `IFCAP_OFF_IRQ_STAT;
   wire        hit_ik2 = paddr == `IFCAP_OFF_IRQ_MASK;
   wire        hit_win = paddr == `IFCAP_OFF_RAW_WIN;
   wire        win_ext = reg_page_select == IFCAP_PG1;
   wire        win_int = reg_page_select == IFCAP_PG2;
   wire        mapped  = hit_er | hit_ir | hit_em | hit_im | hit_ek |
                         hit_ik | hit_ct | hit_st | hit_is | hit_ik2 |
                         hit_win;
   // write of zero clears; ones keep the bit
   wire        clr_ext = wr_acc & lane0 &
                         (hit_er | hit_em | (hit_win & win_ext));
   wire        clr_int = wr_acc & lane0 &
                         (hit_ir | hit_im | (hit_win & win_int));
   wire [7:0]  clr_ext_m = clr_ext ? ~pwdata[7:0] : 8'h00;
   wire [7:0]  clr_int_m = clr_int ? ~pwdata[7:0] : 8'h00;

   assign int_evt = {serial_full_or_tone_evt, callerid_decode_evt, 1'b0,
                     uart_evt, line_energy_evt, counter_two_evt,
                     counter_one_evt, timer_evt};
   // set beats clear in same cycle
   assign ext_raw_next = (ext_raw_reg & ~clr_ext_m) | eif.edge_evt;
   assign int_raw_next = (int_raw_reg & ~clr_int_m) | int_evt;

   assign ext_masked_flags      = ext_raw_reg & ext_mask_reg;
   assign internal_masked_flags = int_raw_reg & int_mask_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ext_raw_reg <= `IFCAP_RST_FLAGS;
         int_raw_reg <= `IFCAP_RST_FLAGS;
      end
      else
      begin
         ext_raw_reg <= ext_raw_next;
         int_raw_reg <= int_raw_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // control registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ext_mask_reg        <= `IFCAP_RST_MASK;
         int_mask_reg        <= `IFCAP_RST_MASK;
         counter_control_reg <= `IFCAP_RST_CTRL;
         reg_page_select     <= `IFCAP_RST_PAGE;
         irq_mask_reg        <= 2'h0;
      end
      else if (wr_acc && lane0)
      begin
         if (hit_ek)
            ext_mask_reg <= pwdata[7:0];
         if (hit_ik)
            int_mask_reg <= pwdata[7:0];
         if (hit_ct)
            counter_control_reg <= pwdata[7:0];
         if (hit_st)
            reg_page_select <= pwdata[`IFCAP_STAT_PAGE_LO +: 2];
         if (hit_ik2)
            irq_mask_reg <= pwdata[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // summary interrupt: bit0 external, bit1 internal; read clears
   wire [1:0] irq_evt  = {|(int_evt & int_mask_reg),
                          |(eif.edge_evt & ext_mask_reg)};
   wire [1:0] irq_clr  = (rd_acc && hit_is) ? 2'h3 : 2'h0;
   assign irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_evt;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_stat_reg <= 2'h0;
      else
         irq_stat_reg <= irq_stat_next;
   end
   assign irq         = |(irq_stat_reg & irq_mask_reg);
   assign irq_pending = |ext_masked_flags | |internal_masked_flags;
   // core branches here on acceptance
   assign irq_vector  = `IFCAP_VECTOR_ADDR;

   ////////////////////////////////////////////////////////////////////
   // read mux
   logic [7:0] win_data;
   logic [7:0] rd_data;
   always_comb
   begin
      case (reg_page_select)
         IFCAP_PG1: win_data = ext_raw_reg;
         IFCAP_PG2: win_data = int_raw_reg;
         default:   win_data = 8'h00;
      endcase
   end
   always_comb
   begin
      rd_data = 8'h00;
      if (hit_er)
         rd_data = ext_raw_reg;
      if (hit_ir)
         rd_data = int_raw_reg;
      if (hit_em)
         rd_data = ext_masked_flags;
      if (hit_im)
         rd_data = internal_masked_flags;
      if (hit_ek)
         rd_data = ext_mask_reg;
      if (hit_ik)
         rd_data = int_mask_reg;
      if (hit_ct)
         rd_data = counter_control_reg;
      if (hit_st)
         rd_data = {reg_page_select, 6'h00};
      if (hit_is)
         rd_data = {6'h00, irq_stat_reg};
      if (hit_ik2)
         rd_data = {6'h00, irq_mask_reg};
      if (hit_win)
         rd_data = win_data;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
         prdata <= {24'h000000, rd_data};
   end
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   ////////////////////////////////////////////////////////////////////
   // pin edge capture
   fall_sets_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      $fell(sync2_reg[2]) |=> ext_raw_reg[2])
      else $error("falling edge missed");

   rise_ignored_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!ext_raw_reg[2] && $rose(sync2_reg[2])) |=> !ext_raw_reg[2])
      else $error("rising edge flagged on low pin");

   ext_bit_map_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      $fell(sync2_reg[0]) |=> ext_raw_reg[0])
      else $error("pin zero not on bit zero");

   rise_p7_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ($rose(sync2_reg[7]) && counter_control_reg[0]) |=> ext_raw_reg[7])
      else $error("pin7 rise missed");

   fall_p7_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ($fell(sync2_reg[7]) && !counter_control_reg[0]) |=> ext_raw_reg[7])
      else $error("pin7 fall missed");

   p7_ignore_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!ext_raw_reg[7] && counter_control_reg[0] && $fell(sync2_reg[7]))
      |=> !ext_raw_reg[7])
      else $error("pin7 wrong edge flagged");

   // software clear, never set
   ext_write_clears_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clr_ext && !pwdata[3] && !eif.edge_evt[3]) |=> !ext_raw_reg[3])
      else $error("ext flag not cleared by write");

   int_write_clears_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clr_int && !pwdata[0] && !int_evt[0]) |=> !int_raw_reg[0])
      else $error("int flag not cleared by write");

   no_sw_set_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!ext_raw_reg[0] && !eif.edge_evt[0]) |=> !ext_raw_reg[0])
      else $error("ext flag set without event");

   no_int_set_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!int_raw_reg[4] && !int_evt[4]) |=> !int_raw_reg[4])
      else $error("int flag set without event");

   // masked and raw views
   mask_zero_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !int_mask_reg[1] |-> !internal_masked_flags[1])
      else $error("masked flag visible");

   ext_mask_zero_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !ext_mask_reg[3] |-> !ext_masked_flags[3])
      else $error("ext masked flag visible");

   pending_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      irq_pending == |{ext_raw_reg & ext_mask_reg,
                       int_raw_reg & int_mask_reg})
      else $error("pending level wrong");

   raw_shows_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      timer_evt |=> int_raw_reg[0])
      else $error("raw timer flag missing");

   raw_ext_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ($fell(sync2_reg[5]) && !ext_mask_reg[5]) |=> ext_raw_reg[5])
      else $error("raw ext flag hidden by mask");

   // internal source map
   unused_zero_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !int_raw_reg[`IFCAP_INT_UNUSED_BIT])
      else $error("unused bit set");

   cid_map_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      callerid_decode_evt |=> int_raw_reg[6])
      else $error("caller id flag missing");

   serial_map_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      serial_full_or_tone_evt |=> int_raw_reg[7])
      else $error("serial or tone flag missing");

   // page window
   win_page_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (reg_page_select == IFCAP_PG2) |-> win_data == int_raw_reg)
      else $error("page window wrong");

   win_ext_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (reg_page_select == IFCAP_PG1) |-> win_data == ext_raw_reg)
      else $error("page one window wrong");

   win_other_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (reg_page_select == IFCAP_PG0 || reg_page_select == IFCAP_PG3)
      |-> win_data == 8'h00)
      else $error("unused page not zero");

   // main scenarios
   cov_ext_c: cover property (@(posedge pclk) disable iff (!presetn)
      clr_ext ##1 irq);
   cov_irq_c: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(irq));
   cov_win_c: cover property (@(posedge pclk) disable iff (!presetn)
      rd_acc && hit_win && win_ext);
   cov_p7_rise_c: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(sync2_reg[7]) && counter_control_reg[0]);
endmodule

// ### hw/ifcap_cfg.svh
`ifndef IFCAP_CFG_SVH
`define IFCAP_CFG_SVH
// apb word offsets
`define IFCAP_OFF_EXT_RAW     12'h000
`define IFCAP_OFF_INT_RAW     12'h004
`define IFCAP_OFF_EXT_MASKED  12'h008
`define IFCAP_OFF_INT_MASKED  12'h00c
`define IFCAP_OFF_EXT_MASK    12'h010
`define IFCAP_OFF_INT_MASK    12'h014
`define IFCAP_OFF_CTRL        12'h018
`define IFCAP_OFF_STATUS      12'h01c
`define IFCAP_OFF_IRQ_STAT    12'h020
`define IFCAP_OFF_IRQ_MASK    12'h024
`define IFCAP_OFF_RAW_WIN     12'h028
// field positions
`define IFCAP_CTRL_P7_RISE    0
`define IFCAP_STAT_PAGE_LO    6
`define IFCAP_INT_UNUSED_BIT  5
// reset values
`define IFCAP_RST_FLAGS       8'h00
`define IFCAP_RST_MASK        8'h00
`define IFCAP_RST_CTRL        8'h00
`define IFCAP_RST_PAGE        2'h0
// interrupt vector
`define IFCAP_VECTOR_ADDR     16'h0008
`endif

// ### hw/ifcap_pkg.sv
package ifcap_pkg;
   typedef enum logic [1:0]
   {
      IFCAP_PG0 = 2'b00,
      IFCAP_PG1 = 2'b01,
      IFCAP_PG2 = 2'b10,
      IFCAP_PG3 = 2'b11
   } ifcap_page_t;
endpackage

// ### hw/ifcap_edge_if.sv
`timescale 1ns/10ps
interface ifcap_edge_if;
   logic [7:0] pin_sync;
   logic       rise_sel;
   logic [7:0] edge_evt;
   modport det (input pin_sync, input rise_sel, output edge_evt);
   modport top (output pin_sync, output rise_sel, input edge_evt);
endinterface

// ### hw/ifcap_edge.sv
`timescale 1ns/10ps
module ifcap_edge
   import ifcap_pkg::*;
(
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // link to top
   ifcap_edge_if.det e
);
   logic [7:0] prev_reg;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prev_reg <= 8'hff;
      else
         prev_reg <= e.pin_sync;
   end
   genvar i;
   generate
      for (i = 0; i < 7; i++)
      begin : g_fall
         assign e.edge_evt[i] = prev_reg[i] & ~e.pin_sync[i];
      end
   endgenerate
   // pin 7 edge polarity from control bit
   assign e.edge_evt[7] = e.rise_sel ? (~prev_reg[7] & e.pin_sync[7])
                                     : (prev_reg[7] & ~e.pin_sync[7]);
endmodule

// ### bench/ifcap_src_model.sv
`timescale 1ns/10ps
module ifcap_src_model
(
   // clock
   input  wire logic pclk,
   // pins and event pulses
   output logic [7:0] pins,
   output logic [6:0] evts
);
   // pins idle high like the pull-ups
   initial
   begin
      pins = 8'hff;
      evts = 7'h00;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic set_pins(input logic [7:0] v);
      @(posedge pclk);
      pins <= v;
   endtask

   task automatic pulse(input logic [6:0] v);
      @(posedge pclk);
      evts <= v;
      @(posedge pclk);
      evts <= 7'h00;
   endtask
endmodule

// ### bench/tb.sv
`timescale 1ns/10ps
`include "ifcap_cfg.svh"
`define CHK(nm, e, g) \
   begin checks++; if ((g) !== (e)) begin n_errors++; \
   $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb
   import ifcap_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd_v;
   logic        pready, pslverr, irq_pending, irq, last_err;
   logic [15:0] irq_vector;
   logic [3:0]  pstrb;
   logic [7:0]  pins;
   logic [6:0]  evts;
   int          n_errors = 0;
   int          checks = 0;
   typedef struct packed {logic [6:0] evt; logic [7:0] raw;} ifcap_row_t;
   ifcap_row_t  rows [7] = '{{7'h01, 8'h01}, {7'h02, 8'h02},
      {7'h04, 8'h04}, {7'h08, 8'h08}, {7'h10, 8'h10},
      {7'h20, 8'h40}, {7'h40, 8'h80}};

   ifcap_src_model src_i (.pclk(pclk), .pins(pins), .evts(evts));
   ifcap_top ifcap_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .port_seven_pins(pins), .timer_evt(evts[0]),
      .counter_one_evt(evts[1]), .counter_two_evt(evts[2]),
      .line_energy_evt(evts[3]), .uart_evt(evts[4]),
      .callerid_decode_evt(evts[5]),
      .serial_full_or_tone_evt(evts[6]), .irq_pending(irq_pending),
      .irq(irq), .irq_vector(irq_vector));

   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
      begin
         n++;
         if (n > 16)
         begin
            n_errors++;
            report_and_stop();
         end
         @(posedge pclk);
      end
      rd_v     = prdata;
      last_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdc(input string nm, input logic [11:0] a,
                      input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      `CHK(nm, {24'h000000, e}, rd_v)
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      pstrb = 4'h1;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (6) @(posedge pclk);
      // internal sources, one row each
      apb(1'b1, `IFCAP_OFF_INT_MASK, 8'hff);
      foreach (rows[i])
      begin
         src_i.pulse(rows[i].evt);
         rdc("int raw", `IFCAP_OFF_INT_RAW, rows[i].raw);
         apb(1'b1, `IFCAP_OFF_INT_MASKED, 8'h00);
         rdc("int clr", `IFCAP_OFF_INT_RAW, 8'h00);
      end
      rdc("irq int", `IFCAP_OFF_IRQ_STAT, 8'h02);
      rdc("ext rst", `IFCAP_OFF_EXT_RAW, 8'h00);
      apb(1'b1, `IFCAP_OFF_EXT_MASK, 8'h0f);
      apb(1'b1, `IFCAP_OFF_IRQ_MASK, 8'h01);
      apb(1'b1, `IFCAP_OFF_EXT_RAW, 8'hff);
      rdc("no set", `IFCAP_OFF_EXT_RAW, 8'h00);
      src_i.set_pins(8'h00);
      repeat (6) @(posedge pclk);
      rdc("ext fall", `IFCAP_OFF_EXT_RAW, 8'hff);
      rdc("ext msk", `IFCAP_OFF_EXT_MASKED, 8'h0f);
      `CHK("irq", 1'b1, irq)
      rdc("irq st", `IFCAP_OFF_IRQ_STAT, 8'h01);
      @(posedge pclk);
      `CHK("irq clr", 1'b0, irq)
      `CHK("pend", 1'b1, irq_pending)
      pstrb <= 4'h0;
      apb(1'b1, `IFCAP_OFF_EXT_RAW, 8'h00);
      pstrb <= 4'h1;
      rdc("strb", `IFCAP_OFF_EXT_RAW, 8'hff);
      apb(1'b1, `IFCAP_OFF_EXT_MASKED, 8'hf0);
      rdc("via msk", `IFCAP_OFF_EXT_RAW, 8'hf0);
      apb(1'b1, `IFCAP_OFF_EXT_RAW, 8'h00);
      rdc("via raw", `IFCAP_OFF_EXT_RAW, 8'h00);
      apb(1'b1, `IFCAP_OFF_CTRL, 8'h01);
      src_i.set_pins(8'hff);
      repeat (6) @(posedge pclk);
      rdc("p7 rise", `IFCAP_OFF_EXT_RAW, 8'h80);
      apb(1'b1, `IFCAP_OFF_EXT_RAW, 8'h00);
      src_i.set_pins(8'h00);
      repeat (6) @(posedge pclk);
      rdc("p7 fall", `IFCAP_OFF_EXT_RAW, 8'h7f);
      apb(1'b1, `IFCAP_OFF_INT_MASK, 8'h00);
      src_i.pulse(7'h01);
      rdc("int off", `IFCAP_OFF_INT_MASKED, 8'h00);
      rdc("int real", `IFCAP_OFF_INT_RAW, 8'h01);
      apb(1'b1, `IFCAP_OFF_STATUS, 8'h40);
      rdc("page1", `IFCAP_OFF_RAW_WIN, 8'h7f);
      apb(1'b1, `IFCAP_OFF_RAW_WIN, 8'h0f);
      rdc("win clr", `IFCAP_OFF_EXT_RAW, 8'h0f);
      apb(1'b1, `IFCAP_OFF_STATUS, 8'h80);
      rdc("page2", `IFCAP_OFF_RAW_WIN, 8'h01);
      apb(1'b1, `IFCAP_OFF_STATUS, 8'hc0);
      rdc("page3", `IFCAP_OFF_RAW_WIN, 8'h00);
      rdc("unmap", 12'h100, 8'h00);
      `CHK("slverr", 1'b1, last_err)
      // mid-run reset with pins idle high
      src_i.set_pins(8'hff);
      repeat (4) @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      `CHK("rst irq", 1'b0, irq)
      rdc("rst ext", `IFCAP_OFF_EXT_RAW, 8'h00);
      rdc("rst int", `IFCAP_OFF_INT_RAW, 8'h00);
      rdc("rst page", `IFCAP_OFF_STATUS, 8'h00);
      `CHK("vector", 16'h0008, irq_vector)
      report_and_stop();
   end
endmodule
